// [rtl/phy_register_scan_engine.sv]
// Purpose: repeats a phy register read at a fixed interval and mirrors the result
// Assumes: host register port is byte wide, synchronous to CLK
// Notes:   read data latency is one clock; reads have no side effects
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - setting scan enable starts the scan and raises busy at once
// - first read completes one interval after start, then repeats each interval
// - data-not-valid flag tells the host when the first read finished
// - read-data registers overwritten every interval, no per-update indication
// - host cancels by clearing scan enable; busy drops once activity stops
// - duplex reset bits follow the second LED pin strap
// - data-not-valid reads 0 after reset, 1 from the start of the first read until it updates the data, then 0
// - scan flag reads 1 while a scan runs, else 0
// - busy reads 1 while a phy register is read, 0 when idle
// - scan enable makes the addressed register be read continuously
module phy_register_scan_engine #(
  parameter int INTERVAL_CYCLES = mgmt_scan_pkg::SCAN_INTERVAL_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       REG_WE,
  input  wire logic [4:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic       MDC,
  input  wire logic       MDIO_I,
  output logic            MDIO_O,
  output logic            MDIO_OE,
  input  wire logic       SECOND_LED_PIN,
  output logic            DUPLEX_MODE,
  output logic            DUPLEX_STATUS
);

  // counter just wide enough to hold INTERVAL_CYCLES - 1
  localparam int CW = $clog2(INTERVAL_CYCLES);
  localparam logic [CW-1:0] CNT_LAST = CW'(INTERVAL_CYCLES - 1);

  // the interval must leave room for a launch and a completion
  if (INTERVAL_CYCLES < 4) begin : g_bad_interval
    $error("INTERVAL_CYCLES too small");
  end

  typedef struct packed {
    logic [4:0]                mgmt_reg_address;
    logic [1:0]                mgmt_command;
    mgmt_scan_pkg::eng_state_t st;
    logic                      scan_mode;
    logic                      single_req;
    logic                      data_not_valid_flag;
    logic [15:0]               read_data_pair;
    logic [CW-1:0]             cnt;
    logic                      frame_done;
    logic [7:0]                rdata_out;
    logic [1:0]                strap_sync;
    logic [1:0]                strap_cnt;
    logic                      strap_done;
    logic                      duplex;
  } eng_reg_t;

  eng_reg_t    s_q;
  eng_reg_t    s_d;
  logic        launch;
  logic        finish;
  logic        busy;
  logic [7:0]  stat_now;
  mgmt_link_if lk ();

  // status byte: upper bits and the reserved bit read as zero
  function automatic logic [7:0] status_byte(input eng_reg_t r);
    logic [7:0] v;
    v = 8'h00;
    v[mgmt_scan_pkg::STAT_BUSY_BIT]   = (r.st != mgmt_scan_pkg::ST_IDLE);
    v[mgmt_scan_pkg::STAT_SCAN_BIT]   = (r.st != mgmt_scan_pkg::ST_IDLE) && r.scan_mode;
    v[mgmt_scan_pkg::STAT_DATA_NOT_VALID_FLAG_BIT] = r.data_not_valid_flag;
    return v;
  endfunction

  // read mux for the host port; unmapped offsets read zero
  function automatic logic [7:0] reg_read(input logic [4:0] a, input eng_reg_t r);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      mgmt_scan_pkg::OFS_MGMT_REG_ADDRESS: v = {3'h0, r.mgmt_reg_address};
      mgmt_scan_pkg::OFS_MGMT_COMMAND:     v = {6'h00, r.mgmt_command};
      mgmt_scan_pkg::OFS_MGMT_STATUS:      v = status_byte(r);
      mgmt_scan_pkg::OFS_READ_DATA_LOW:    v = r.read_data_pair[7:0];
      mgmt_scan_pkg::OFS_READ_DATA_HIGH:   v = r.read_data_pair[15:8];
      default:                             v = 8'h00;
    endcase
    return v;
  endfunction

  // next state: host writes, scan sequencing, strap capture
  always_comb begin
    s_d          = s_q;
    launch       = 1'b0;
    finish       = 1'b0;
    s_d.rdata_out = reg_read(REG_ADDR, s_q);
    // host register writes; the address steers every following read
    if (REG_WE && REG_ADDR == mgmt_scan_pkg::OFS_MGMT_REG_ADDRESS) begin
      s_d.mgmt_reg_address = REG_WDATA[4:0];
    end
    if (REG_WE && REG_ADDR == mgmt_scan_pkg::OFS_MGMT_COMMAND) begin
      s_d.mgmt_command = REG_WDATA[1:0];
    end
    unique case (s_q.st)
      mgmt_scan_pkg::ST_IDLE: begin
        if (s_q.mgmt_command[mgmt_scan_pkg::CMD_SCAN_ENABLE_BIT]) begin
          launch        = 1'b1;
          s_d.st        = mgmt_scan_pkg::ST_RUN;
          s_d.scan_mode = 1'b1;
          s_d.data_not_valid_flag    = 1'b1;
          s_d.cnt       = '0;
          s_d.single_req = 1'b0;
        end else if (s_q.single_req) begin
          launch        = 1'b1;
          s_d.st        = mgmt_scan_pkg::ST_RUN;
          s_d.scan_mode = 1'b0;
          s_d.data_not_valid_flag    = 1'b1;
          s_d.cnt       = '0;
          s_d.single_req = 1'b0;
        end
      end
      mgmt_scan_pkg::ST_RUN: begin
        // interval counted on CLK; a frame the link clock has not finished by the last count goes on in drain
        if (s_q.cnt == CNT_LAST) begin
          if (s_q.frame_done) begin
            finish = 1'b1;
          end else begin
            s_d.st = mgmt_scan_pkg::ST_DRAIN;
          end
        end else begin
          s_d.cnt = s_q.cnt + CW'(1);
        end
      end
      mgmt_scan_pkg::ST_DRAIN: begin
        // the link clock stalled; hold busy until the frame ends
        if (s_q.frame_done) begin
          finish = 1'b1;
        end
      end
      default: begin
        s_d.st = mgmt_scan_pkg::ST_IDLE;
      end
    endcase
    // completion: update data silently, then repeat or stop
    if (finish) begin
      s_d.read_data_pair = lk.rdata;
      s_d.data_not_valid_flag         = 1'b0;
      if (s_q.scan_mode && s_q.mgmt_command[mgmt_scan_pkg::CMD_SCAN_ENABLE_BIT]) begin
        launch  = 1'b1;
        s_d.cnt = '0;
        s_d.st  = mgmt_scan_pkg::ST_RUN;
      end else begin
        s_d.st        = mgmt_scan_pkg::ST_IDLE;
        s_d.scan_mode = 1'b0;
      end
    end
    // single read request taken only while idle; dropped if a read launches in the same cycle
    if (REG_WE && REG_ADDR == mgmt_scan_pkg::OFS_MGMT_COMMAND &&
        REG_WDATA[mgmt_scan_pkg::CMD_SINGLE_READ_BIT] &&
        s_q.st == mgmt_scan_pkg::ST_IDLE && !launch) begin
      s_d.single_req = 1'b1;
    end
    if (launch) begin
      s_d.frame_done = 1'b0;
    end
    if (lk.done) begin
      s_d.frame_done = 1'b1;
    end
    // strap: settle through the synchroniser, then catch once
    s_d.strap_sync = {s_q.strap_sync[0], SECOND_LED_PIN};
    if (!s_q.strap_done) begin
      if (s_q.strap_cnt == mgmt_scan_pkg::STRAP_SETTLE) begin
        s_d.duplex     = s_q.strap_sync[1];
        s_d.strap_done = 1'b1;
      end else begin
        s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // busy covers the whole operation, from launch until the data lands
  assign busy          = (s_q.st != mgmt_scan_pkg::ST_IDLE);
  assign stat_now      = status_byte(s_q);
  assign lk.start      = launch;
  assign lk.reg_addr   = s_q.mgmt_reg_address;
  assign REG_RDATA     = s_q.rdata_out;
  assign DUPLEX_MODE   = s_q.duplex;
  assign DUPLEX_STATUS = s_q.duplex;

  // one serial read engine; start is only raised while it is idle
  mgmt_read_frame u_frame (
    .clk     (CLK),
    .rst     (RST),
    .lk      (lk),
    .mdc     (MDC),
    .mdio_i  (MDIO_I),
    .mdio_o  (MDIO_O),
    .mdio_oe (MDIO_OE)
  );

  // all checks below run on CLK and rest during reset
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_scan_request;
    !busy && s_q.mgmt_command[mgmt_scan_pkg::CMD_SCAN_ENABLE_BIT];
  endsequence
  sequence s_tick_ready;
    s_q.st == mgmt_scan_pkg::ST_RUN && s_q.cnt == CNT_LAST && s_q.frame_done;
  endsequence

  a_busy_on_scan: assert property (s_scan_request |=> busy && s_q.scan_mode)
    else $error("busy not raised after scan enable");
  a_interval_tick: assert property (finish |-> s_q.cnt == CNT_LAST)
    else $error("read completed off the interval");
  a_update_data: assert property (s_tick_ready |=> s_q.read_data_pair == $past(lk.rdata))
    else $error("read data not updated at interval");
  a_data_not_valid_flag_clears: assert property (finish |=> !s_q.data_not_valid_flag)
    else $error("data-not-valid still set after read");
  a_data_not_valid_flag_sets: assert property (s_scan_request |=> s_q.data_not_valid_flag [*2])
    else $error("data-not-valid not set at scan start");
  a_scan_flag: assert property (stat_now[mgmt_scan_pkg::STAT_SCAN_BIT] |-> busy)
    else $error("scan flag while idle");
  a_busy_idle_link: assert property (!busy |-> !lk.busy)
    else $error("frame active while idle");
  a_scan_repeats: assert property (s_tick_ready ##0
    s_q.mgmt_command[mgmt_scan_pkg::CMD_SCAN_ENABLE_BIT] && s_q.scan_mode
    |-> launch ##1 busy)
    else $error("scan did not relaunch");
  a_cancel_drains: assert property ($fell(busy) |-> $past(finish))
    else $error("busy dropped without completing read");
  a_no_stray_launch: assert property (launch && busy |-> finish)
    else $error("read launched while one in flight");
  a_strap_capture: assert property ($rose(s_q.strap_done)
    |-> DUPLEX_MODE == $past(s_q.strap_sync[1]) && DUPLEX_STATUS == DUPLEX_MODE)
    else $error("duplex reset not taken from strap");

  // scan flag only comes up from a scan request, never from a single read
  a_scan_from_enable: assert property ($rose(stat_now[mgmt_scan_pkg::STAT_SCAN_BIT])
    |-> $past(s_q.mgmt_command[mgmt_scan_pkg::CMD_SCAN_ENABLE_BIT]))
    else $error("scan flag raised without scan enable");
  // a single read runs busy but never shows the scan flag
  a_single_no_scan: assert property (s_q.single_req && !busy &&
    !s_q.mgmt_command[mgmt_scan_pkg::CMD_SCAN_ENABLE_BIT]
    |=> busy && !stat_now[mgmt_scan_pkg::STAT_SCAN_BIT])
    else $error("single read shows scan flag");
  // a single read lands once and goes idle instead of repeating
  a_single_once: assert property (finish && !s_q.scan_mode |=> !busy)
    else $error("single read repeated");
  // busy can only drop through a completion, so a cancel waits for the read
  a_busy_holds: assert property (busy && !finish |=> busy)
    else $error("busy dropped mid read");
  // data-not-valid only clears when a read lands
  a_data_not_valid_flag_holds: assert property (s_q.data_not_valid_flag && !finish |=> s_q.data_not_valid_flag)
    else $error("data-not-valid cleared early");
  // read data only moves at a completion, never in between
  a_data_stable: assert property (!finish |=> $stable(s_q.read_data_pair))
    else $error("read data changed between reads");
  // reserved and unused status bits read as zero
  a_status_zero: assert property (stat_now[7:3] == 5'h00)
    else $error("unused status bits set");
  // the link must be idle whenever a new frame is started, or the start is lost
  a_launch_link_idle: assert property (launch |-> !lk.busy)
    else $error("frame started while link busy");
  // every launch restarts the interval count
  a_launch_count: assert property (launch |=> s_q.cnt == '0)
    else $error("interval count not restarted");
  // a stalled link clock sends a late frame to the drain state
  a_drain_entry: assert property (s_q.st == mgmt_scan_pkg::ST_RUN &&
    s_q.cnt == CNT_LAST && !s_q.frame_done |=> s_q.st == mgmt_scan_pkg::ST_DRAIN)
    else $error("late frame did not enter drain");
  // frames only finish while the engine reports busy
  a_done_while_busy: assert property (lk.done |-> busy)
    else $error("frame finished while idle");
  // strap value is caught once and then held
  a_strap_held: assert property (s_q.strap_done |=> $stable(s_q.duplex))
    else $error("duplex bits changed after capture");
  // once scan enable is clear, the next completion stops the engine
  sequence s_cancel_seen;
    busy && !s_q.mgmt_command[mgmt_scan_pkg::CMD_SCAN_ENABLE_BIT];
  endsequence
  a_cancel_stops: assert property (s_cancel_seen ##0 finish |=> !busy)
    else $error("scan relaunched after cancel");

endmodule // phy_register_scan_engine
`default_nettype wire

// [common/mgmt_scan_pkg.sv]
// Purpose: shared constants and types for the management scan engine
// Assumes: 250 MHz system clock; byte-wide host register port
// Notes:   phy map offsets kept for software that reaches the phy through this engine
`default_nettype none
package mgmt_scan_pkg;

  // system clock and read interval (10.24 us)
  localparam int CLK_MHZ          = 250;
  localparam int SCAN_INTERVAL_NS = 10240;
  localparam int SCAN_INTERVAL_CYC = (SCAN_INTERVAL_NS * CLK_MHZ) / 1000;

  // management register port offsets
  localparam logic [4:0] OFS_MGMT_REG_ADDRESS = 5'h00;
  localparam logic [4:0] OFS_MGMT_COMMAND     = 5'h01;
  localparam logic [4:0] OFS_MGMT_STATUS      = 5'h02;
  localparam logic [4:0] OFS_READ_DATA_LOW    = 5'h03;
  localparam logic [4:0] OFS_READ_DATA_HIGH   = 5'h04;

  // phy register map, targets for the address register
  localparam logic [4:0] PHY_STATUS_ONE        = 5'h01;
  localparam logic [4:0] PHY_IDENT_HIGH        = 5'h02;
  localparam logic [4:0] PHY_IDENT_LOW         = 5'h03;
  localparam logic [4:0] PHY_CONTROL_TWO       = 5'h10;
  localparam logic [4:0] PHY_STATUS_TWO        = 5'h11;
  localparam logic [4:0] PHY_INTERRUPT_ENABLE  = 5'h12;
  localparam logic [4:0] PHY_INTERRUPT_REQUEST = 5'h13;
  localparam logic [4:0] PHY_LED_CONFIG        = 5'h14;

  // command and status bit positions
  localparam int CMD_SINGLE_READ_BIT = 0;
  localparam int CMD_SCAN_ENABLE_BIT = 1;
  localparam int STAT_BUSY_BIT       = 0;
  localparam int STAT_SCAN_BIT       = 1;
  localparam int STAT_DATA_NOT_VALID_FLAG_BIT     = 2;

  // reset values
  localparam logic [4:0]  MGMT_REG_ADDRESS_RST = 5'h00;
  localparam logic [1:0]  MGMT_COMMAND_RST     = 2'h0;
  localparam logic [15:0] READ_DATA_RST        = 16'h0000;

  // serial read frame layout
  localparam logic [1:0] FRAME_START    = 2'h1;
  localparam logic [1:0] FRAME_OP_READ  = 2'h2;
  localparam logic [4:0] FRAME_PHY_ADDR = 5'h00;
  localparam logic [4:0] FRAME_HDR_BITS = 5'h0E;
  localparam logic [4:0] FRAME_TA_END   = 5'h10;
  localparam logic [4:0] FRAME_LAST     = 5'h1F;

  // strap capture waits for the two synchroniser stages
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_DRAIN = 2'b10
  } eng_state_t;

endpackage
`default_nettype wire

// [common/mgmt_link_if.sv]
// Purpose: carrier between the scan sequencer and the serial read engine
// Assumes: both ends on the system clock
// Notes:   start is a one-cycle pulse, done a one-cycle pulse, rdata held
`timescale 1ns/1ps
`default_nettype none
interface mgmt_link_if;
  logic        start;
  logic [4:0]  reg_addr;
  logic        busy;
  logic        done;
  logic [15:0] rdata;
  modport engine (output start, output reg_addr, input busy, input done, input rdata);
  modport link   (input start, input reg_addr, output busy, output done, output rdata);
endinterface
`default_nettype wire

// [rtl/mgmt_read_frame.sv]
// Purpose: shifts one serial read frame to the phy and gathers 16 bits back
// Assumes: management clock arrives as a slow pin, sampled by the system clock
// Notes:   bits move on sampled rising edges of the management clock
`timescale 1ns/1ps
`default_nettype none
module mgmt_read_frame (
  input  wire logic         clk,
  input  wire logic         rst,
  mgmt_link_if.link         lk,
  input  wire logic         mdc,
  input  wire logic         mdio_i,
  output logic              mdio_o,
  output logic              mdio_oe
);

  typedef struct packed {
    logic [2:0]  mdc_sync;
    logic [1:0]  mdio_sync;
    logic        active;
    logic [4:0]  bitcnt;
    logic [13:0] hdr;
    logic [15:0] rx;
    logic [15:0] rdata;
    logic        done;
    logic        mdio_o;
    logic        mdio_oe;
  } frame_state_t;

  frame_state_t s_q;
  frame_state_t s_d;
  logic         mdc_rise;

  // stage 0 feeds only stage 1; the edge is found between stages 1 and 2
  assign mdc_rise = s_q.mdc_sync[1] & ~s_q.mdc_sync[2];

  // frame sequencing: header out, turnaround released, data in
  always_comb begin
    s_d           = s_q;
    s_d.mdc_sync  = {s_q.mdc_sync[1:0], mdc};
    s_d.mdio_sync = {s_q.mdio_sync[0], mdio_i};
    s_d.done      = 1'b0;
    if (lk.start && !s_q.active) begin
      s_d.active = 1'b1;
      s_d.bitcnt = 5'h00;
      s_d.hdr    = {mgmt_scan_pkg::FRAME_START, mgmt_scan_pkg::FRAME_OP_READ,
                    mgmt_scan_pkg::FRAME_PHY_ADDR, lk.reg_addr};
    end else if (s_q.active && mdc_rise) begin
      if (s_q.bitcnt < mgmt_scan_pkg::FRAME_HDR_BITS) begin
        s_d.mdio_o  = s_q.hdr[13];
        s_d.mdio_oe = 1'b1;
        s_d.hdr     = {s_q.hdr[12:0], 1'b0};
      end else begin
        s_d.mdio_o  = 1'b0;
        s_d.mdio_oe = 1'b0;
      end
      if (s_q.bitcnt >= mgmt_scan_pkg::FRAME_TA_END) begin
        s_d.rx = {s_q.rx[14:0], s_q.mdio_sync[1]};
      end
      if (s_q.bitcnt == mgmt_scan_pkg::FRAME_LAST) begin
        s_d.active = 1'b0;
        s_d.done   = 1'b1;
        s_d.rdata  = {s_q.rx[14:0], s_q.mdio_sync[1]};
      end else begin
        s_d.bitcnt = s_q.bitcnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lk.busy  = s_q.active;
  assign lk.done  = s_q.done;
  assign lk.rdata = s_q.rdata;
  assign mdio_o   = s_q.mdio_o;
  assign mdio_oe  = s_q.mdio_oe;

  // the pin is released before the phy answers
  a_release_turnaround: assert property (@(posedge clk) disable iff (rst)
    (s_q.mdio_oe |-> s_q.active && s_q.bitcnt <= mgmt_scan_pkg::FRAME_HDR_BITS))
    else $error("mdio driven outside header");

endmodule // mgmt_read_frame
`default_nettype wire

// [verification/phy_mgmt_model.sv]
// Purpose: phy side of the management link; answers serial read frames from a register array
// Assumes: frame is start 01, op 10, phy address, register address, turnaround, 16 data bits
// Notes:   mdc runs free here, a shortcut against a gated clock; a released line reads high
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_model #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  output logic      mdc,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      mdio_i,
  input  wire logic slow
);
  logic [15:0] regs [32];
  logic [5:0]  cnt_q   = 6'h00;
  logic [13:0] hdr_q   = 14'h0000;
  logic [15:0] shift_q = 16'h0000;
  logic        drv_q   = 1'b0;
  logic        bit_q   = 1'b1;

  // slow mode stretches one frame past a whole read interval
  initial begin
    mdc = 1'b0;
    forever begin
      #((slow === 1'b1) ? 125.0 : 62.5);
      mdc = ~mdc;
    end
  end

  // wire level: device, then phy, else the pull-up
  assign mdio_i = mdio_oe ? mdio_o : (drv_q ? bit_q : 1'b1);

  // header bits captured on rising edges; a frame opens with a driven zero
  always @(posedge mdc) begin
    if (cnt_q == 6'h00) begin
      if (mdio_oe && !mdio_o) begin
        cnt_q <= 6'h01;
        hdr_q <= 14'h0000;
      end
    end else begin
      if (cnt_q <= 6'h0D) hdr_q <= {hdr_q[12:0], mdio_i};
      cnt_q <= (cnt_q == 6'h1F) ? 6'h00 : cnt_q + 6'h01;
    end
  end

  // drive on falling edges so each bit is steady around the sampling edge;
  // data bit 15 must stand at the engine's rise 16, so it goes out after rise 15
  always @(negedge mdc) begin
    if (cnt_q == 6'h0E && hdr_q[13:10] == 4'h6 && hdr_q[9:5] == PHY_ADDR) begin
      drv_q   <= 1'b1;
      bit_q   <= 1'b0;
      shift_q <= regs[hdr_q[4:0]];
    end else if (drv_q && cnt_q >= 6'h0F) begin
      bit_q   <= shift_q[15];
      shift_q <= {shift_q[14:0], 1'b0};
    end else begin
      drv_q <= 1'b0;
    end
  end
endmodule // phy_mgmt_model
`default_nettype wire

// [verification/phy_register_scan_engine_bench.sv]
// Purpose: self-checking bench for the phy register scan engine
// Assumes: read interval shortened to IV cycles, still longer than one frame
// Notes:   one map entry runs with a slow link clock so a read outlasts its interval
`timescale 1ns/1ps
`default_nettype none
module phy_register_scan_engine_bench;
  localparam int IV = 1600;
  logic        CLK;
  logic        RST;
  logic        REG_WE;
  logic [4:0]  REG_ADDR;
  logic [7:0]  REG_WDATA;
  logic [7:0]  REG_RDATA;
  logic        MDC;
  logic        MDIO_I;
  logic        MDIO_O;
  logic        MDIO_OE;
  logic        SECOND_LED_PIN;
  logic        DUPLEX_MODE;
  logic        DUPLEX_STATUS;
  logic        phy_slow;
  logic        strap;
  logic [7:0]  rd;
  logic [15:0] val;
  logic [4:0]  map [8];
  int          err_total;
  int          samples_checked;
  int          n;

  phy_register_scan_engine #(.INTERVAL_CYCLES(IV)) phy_register_scan_engine_i (
    .CLK(CLK), .RST(RST), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .MDC(MDC), .MDIO_I(MDIO_I), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE),
    .SECOND_LED_PIN(SECOND_LED_PIN), .DUPLEX_MODE(DUPLEX_MODE), .DUPLEX_STATUS(DUPLEX_STATUS));
  phy_mgmt_model phy_mgmt_model_i (
    .mdc(MDC), .mdio_o(MDIO_O), .mdio_oe(MDIO_OE), .mdio_i(MDIO_I), .slow(phy_slow));

  // 250 MHz system clock
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // expected status byte
  function automatic logic [7:0] stat_byte(input logic busy, input logic scan, input logic nv);
    return {5'h00, nv, scan, busy};
  endfunction

  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_win(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("mismatch t=%0t cycles=%h low=%h", $time, got, lo);
    end
  endtask

  // host port cycles, inputs moved on the falling edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge CLK);
    REG_WE    = 1'b1;
    REG_ADDR  = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WE = 1'b0;
  endtask

  task automatic rd8(input logic [4:0] a, output logic [7:0] v);
    @(negedge CLK);
    REG_ADDR = a;
    @(negedge CLK);
    v = REG_RDATA;
  endtask

  task automatic check_data(input logic [15:0] v);
    rd8(mgmt_scan_pkg::OFS_READ_DATA_LOW, rd);
    check8(rd, v[7:0]);
    rd8(mgmt_scan_pkg::OFS_READ_DATA_HIGH, rd);
    check8(rd, v[15:8]);
  endtask

  // poll status every cycle; a bound that runs out ends the run
  task automatic wait_stat(input logic [7:0] mask, input logic [7:0] want, input int lim,
                           output int cyc);
    cyc = 0;
    @(negedge CLK);
    REG_ADDR = mgmt_scan_pkg::OFS_MGMT_STATUS;
    do begin
      @(negedge CLK);
      cyc++;
    end while ((REG_RDATA & mask) !== want && cyc < lim);
    if (cyc >= lim) begin
      err_total++;
      $display("mismatch t=%0t status=%h want=%h", $time, REG_RDATA & mask, want);
      wrap_up();
    end
  endtask

  // main sequence: reset values, then a scan of every phy map entry
  initial begin
    err_total = 0;
    samples_checked = 0;
    void'($urandom(83383));
    strap = 1'($urandom);
    RST = 1'b1;
    REG_WE = 1'b0;
    REG_ADDR = 5'h00;
    REG_WDATA = 8'h00;
    SECOND_LED_PIN = strap;
    phy_slow = 1'b0;
    map = '{mgmt_scan_pkg::PHY_STATUS_ONE, mgmt_scan_pkg::PHY_IDENT_HIGH,
            mgmt_scan_pkg::PHY_IDENT_LOW, mgmt_scan_pkg::PHY_CONTROL_TWO,
            mgmt_scan_pkg::PHY_STATUS_TWO, mgmt_scan_pkg::PHY_INTERRUPT_ENABLE,
            mgmt_scan_pkg::PHY_INTERRUPT_REQUEST, mgmt_scan_pkg::PHY_LED_CONFIG};
    for (int i = 0; i < 32; i++) phy_mgmt_model_i.regs[i] = 16'($urandom);
    repeat (20) @(posedge CLK);
    @(negedge CLK);
    RST = 1'b0;
    repeat (4) @(negedge CLK);
    check8({7'h00, DUPLEX_MODE}, {7'h00, strap});
    check8({7'h00, DUPLEX_STATUS}, {7'h00, strap});
    for (int a = 0; a < 5; a++) begin
      rd8(5'(a), rd);
      check8(rd, 8'h00);
    end
    rd8(5'h1F, rd);
    check8(rd, 8'h00);
    wr(mgmt_scan_pkg::OFS_MGMT_STATUS, 8'hFF);
    rd8(mgmt_scan_pkg::OFS_MGMT_STATUS, rd);
    check8(rd, 8'h00);
    foreach (map[k]) begin
      phy_slow = (k == 3);
      wr(mgmt_scan_pkg::OFS_MGMT_REG_ADDRESS, {3'h0, map[k]});
      wr(mgmt_scan_pkg::OFS_MGMT_COMMAND, 8'h02);
      rd8(mgmt_scan_pkg::OFS_MGMT_STATUS, rd);
      check8(rd, stat_byte(1'b1, 1'b1, 1'b1));
      wait_stat(8'h04, 8'h00, 3 * IV, n);
      if (phy_slow) check_win(n, IV, 3 * IV);
      else check_win(n, IV - 8, IV + 4);
      check_data(phy_mgmt_model_i.regs[map[k]]);
      // new phy value lands before the relaunched frame reaches its data bits
      val = 16'($urandom);
      phy_mgmt_model_i.regs[map[k]] = val;
      repeat (2 * IV) @(negedge CLK);
      rd8(mgmt_scan_pkg::OFS_MGMT_STATUS, rd);
      check8(rd, stat_byte(1'b1, 1'b1, 1'b0));
      check_data(val);
      wr(mgmt_scan_pkg::OFS_MGMT_COMMAND, 8'h00);
      rd8(mgmt_scan_pkg::OFS_MGMT_STATUS, rd);
      check8(rd & 8'h01, 8'h01);
      wait_stat(8'h07, 8'h00, 3 * IV, n);
    end
    // single read: one frame, no scan flag, no repeat while the bit stays set
    wr(mgmt_scan_pkg::OFS_MGMT_REG_ADDRESS, {3'h0, mgmt_scan_pkg::PHY_STATUS_TWO});
    wr(mgmt_scan_pkg::OFS_MGMT_COMMAND, 8'h01);
    rd8(mgmt_scan_pkg::OFS_MGMT_STATUS, rd);
    check8(rd, stat_byte(1'b1, 1'b0, 1'b1));
    wait_stat(8'h07, 8'h00, 3 * IV, n);
    check_win(n, IV - 8, IV + 4);
    check_data(phy_mgmt_model_i.regs[mgmt_scan_pkg::PHY_STATUS_TWO]);
    repeat (IV + 8) @(negedge CLK);
    rd8(mgmt_scan_pkg::OFS_MGMT_STATUS, rd);
    check8(rd, 8'h00);
    wr(mgmt_scan_pkg::OFS_MGMT_COMMAND, 8'h00);
    wrap_up();
  end
endmodule // phy_register_scan_engine_bench
`default_nettype wire
